/* File: src/wpc_pkg.sv */
// package: register map, field positions and reset values of the guard block
package wpc_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] WPC_OFS_WRITE_PROTECT_CLEAR = 8'h00;
    localparam logic [7:0] WPC_OFS_WRITE_PROTECT_SET = 8'h04;
    localparam logic [31:0] WPC_RESET_VALUE = 32'h0080_0000;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int WPC_POS_EVENT = 1;
    localparam int WPC_POS_SERIAL_LO = 2;
    localparam int WPC_NUM_SERIAL = 6;
    localparam int WPC_POS_TIMER_LO = 8;
    localparam int WPC_NUM_TIMER = 8;
    localparam int WPC_POS_ADC = 16;
    localparam int WPC_POS_COMPARATOR = 17;
    localparam int WPC_POS_DAC = 18;
    localparam int WPC_POS_TOUCH = 19;
    localparam logic [31:0] WPC_GUARD_MASK = 32'h000f_fffe;
    localparam logic [31:0] WPC_UNMAPPED_READ = 32'h0000_0000;
    // ------------------------------------------------------------
    // apb access kinds
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        WPC_ACC_NONE,
        WPC_ACC_CLEAR,
        WPC_ACC_SET,
        WPC_ACC_BAD
    } wpc_access_e;
endpackage : wpc_pkg

/* File: src/wpc_guard_bit.sv */
// module: one protection flag with write-one-to-clear and set inputs
`timescale 1ns/1ps
module wpc_guard_bit
    import wpc_pkg::*;
#(
    parameter logic RESET_BIT = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // write strobes
    input wire logic clear_hit,
    input wire logic set_hit,
    input wire logic wdata_bit,
    // state
    output logic protect
);
    // a one clears on clear_hit and sets on set_hit; zero writes leave the flag alone
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            protect <= RESET_BIT;
        end else if (clk_en) begin
            if (clear_hit && wdata_bit) begin
                protect <= 1'b0;
            end else if (set_hit && wdata_bit) begin
                protect <= 1'b1;
            end
        end
    end
endmodule : wpc_guard_bit

/* File: src/wpc_top.sv */
// module: peripheral write protection clear register behind an apb slave
// ------------------------------------------------------------
// Functional notes
// - 32-bit clear register at offset zero, reset value 0x00800000.
// - writing zero to a guard bit leaves its protection unchanged.
// - writing one to a guard bit removes that peripheral's protection.
// - reading a guard bit gives one if protected, zero if not.
// - bits 15..8 guard timer/counters seven down to zero.
// - bits 7..2 guard serial interfaces five..zero; bit 1 events.
// ------------------------------------------------------------
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module wpc_top
    import wpc_pkg::*;
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic CLOCK_EN,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // protection state toward the peripherals
    output logic TOUCH_CONTROLLER_GUARD,
    output logic DAC_GUARD,
    output logic COMPARATOR_GUARD,
    output logic ADC_GUARD,
    output logic [WPC_NUM_TIMER-1:0] TIMER_COUNTER_GUARD,
    output logic [WPC_NUM_SERIAL-1:0] SERIAL_INTERFACE_GUARD,
    output logic EVENT_SYSTEM_GUARD
);
    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wpc_access_e access;
    logic setup;
    logic clear_hit;
    logic set_hit;
    logic [31:0] write_protect_clear;
    logic [31:0] read_value;
    logic unmapped;

    // no wait state: the answer is given in the cycle after setup
    assign setup = PSEL && !PENABLE;

    // state moves only at the access edge, never during setup
    always_comb begin
        access = WPC_ACC_NONE;
        if (PSEL && PENABLE && PREADY) begin
            case (PADDR)
                WPC_OFS_WRITE_PROTECT_CLEAR: access = WPC_ACC_CLEAR;
                WPC_OFS_WRITE_PROTECT_SET: access = WPC_ACC_SET;
                default: access = WPC_ACC_BAD;
            endcase
        end
    end

    assign clear_hit = (access == WPC_ACC_CLEAR) && PWRITE;
    assign set_hit = (access == WPC_ACC_SET) && PWRITE;

    // ------------------------------------------------------------
    // guard flags
    // ------------------------------------------------------------
    // reserved bits hold their reset constant and ignore writes
    genvar i;
    generate
        for (i = 0; i < 32; i++) begin : g_bit
            if (WPC_GUARD_MASK[i]) begin : g_guard
                wpc_guard_bit #(
                    .RESET_BIT(WPC_RESET_VALUE[i])
                ) u_bit (
                    .clk(CLOCK),
                    .reset_n(RESET_N),
                    .clk_en(CLOCK_EN),
                    .clear_hit(clear_hit),
                    .set_hit(set_hit),
                    .wdata_bit(PWDATA[i]),
                    .protect(write_protect_clear[i])
                );
            end else begin : g_resv
                assign write_protect_clear[i] = WPC_RESET_VALUE[i];
            end
        end
    endgenerate

    // both mapped words read back the live protection state
    always_comb begin
        case (PADDR)
            WPC_OFS_WRITE_PROTECT_CLEAR: read_value = write_protect_clear;
            WPC_OFS_WRITE_PROTECT_SET: read_value = write_protect_clear;
            default: read_value = WPC_UNMAPPED_READ;
        endcase
    end

    // ------------------------------------------------------------
    // apb answer
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            PREADY <= 1'b0;
        end else if (CLOCK_EN) begin
            PREADY <= setup;
        end
    end

    // unmapped words answer with an error and never touch state
    assign unmapped = (PADDR != WPC_OFS_WRITE_PROTECT_CLEAR) &&
                      (PADDR != WPC_OFS_WRITE_PROTECT_SET);

    // read data stands only in the access cycle; zero otherwise
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            PRDATA <= 32'h0000_0000;
        end else if (CLOCK_EN) begin
            if (setup && !PWRITE) begin
                PRDATA <= read_value;
            end else begin
                PRDATA <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            PSLVERR <= 1'b0;
        end else if (CLOCK_EN) begin
            PSLVERR <= setup && unmapped;
        end
    end

    // ------------------------------------------------------------
    // field views of the live register
    // ------------------------------------------------------------
    // named slices keep the output flops free of index arithmetic
    logic touch_now;
    logic dac_now;
    logic comparator_now;
    logic adc_now;
    logic [WPC_NUM_TIMER-1:0] timer_now;
    logic [WPC_NUM_SERIAL-1:0] serial_now;
    logic event_now;

    assign touch_now = write_protect_clear[WPC_POS_TOUCH];
    assign dac_now = write_protect_clear[WPC_POS_DAC];
    assign comparator_now = write_protect_clear[WPC_POS_COMPARATOR];
    assign adc_now = write_protect_clear[WPC_POS_ADC];
    assign timer_now =
        write_protect_clear[WPC_POS_TIMER_LO +: WPC_NUM_TIMER];
    assign serial_now =
        write_protect_clear[WPC_POS_SERIAL_LO +: WPC_NUM_SERIAL];
    assign event_now = write_protect_clear[WPC_POS_EVENT];

    // ------------------------------------------------------------
    // outputs toward the peripherals
    // ------------------------------------------------------------
    // registered copies keep the outputs flop-driven; they run one
    // cycle behind the register, so a guarded peripheral still sees
    // protection for one cycle after the clearing write lands
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            TOUCH_CONTROLLER_GUARD <= WPC_RESET_VALUE[WPC_POS_TOUCH];
        end else if (CLOCK_EN) begin
            TOUCH_CONTROLLER_GUARD <= touch_now;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            DAC_GUARD <= WPC_RESET_VALUE[WPC_POS_DAC];
        end else if (CLOCK_EN) begin
            DAC_GUARD <= dac_now;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            COMPARATOR_GUARD <= WPC_RESET_VALUE[WPC_POS_COMPARATOR];
        end else if (CLOCK_EN) begin
            COMPARATOR_GUARD <= comparator_now;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            ADC_GUARD <= WPC_RESET_VALUE[WPC_POS_ADC];
        end else if (CLOCK_EN) begin
            ADC_GUARD <= adc_now;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            TIMER_COUNTER_GUARD <=
                WPC_RESET_VALUE[WPC_POS_TIMER_LO +: WPC_NUM_TIMER];
        end else if (CLOCK_EN) begin
            TIMER_COUNTER_GUARD <= timer_now;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            SERIAL_INTERFACE_GUARD <=
                WPC_RESET_VALUE[WPC_POS_SERIAL_LO +: WPC_NUM_SERIAL];
        end else if (CLOCK_EN) begin
            SERIAL_INTERFACE_GUARD <= serial_now;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            EVENT_SYSTEM_GUARD <= WPC_RESET_VALUE[WPC_POS_EVENT];
        end else if (CLOCK_EN) begin
            EVENT_SYSTEM_GUARD <= event_now;
        end
    end
endmodule : wpc_top

/* File: verif/wpc_top_props.sv */
// checker: bus timing and guard-state properties of the clear register
`timescale 1ns/1ps
module wpc_top_props
    import wpc_pkg::*;
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic CLOCK_EN,
    // apb
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // guards
    input wire logic TOUCH_CONTROLLER_GUARD,
    input wire logic DAC_GUARD,
    input wire logic COMPARATOR_GUARD,
    input wire logic ADC_GUARD,
    input wire logic [WPC_NUM_TIMER-1:0] TIMER_COUNTER_GUARD,
    input wire logic [WPC_NUM_SERIAL-1:0] SERIAL_INTERFACE_GUARD,
    input wire logic EVENT_SYSTEM_GUARD
);
    // guards lag the register by one cycle, hence the ##2 below
    wire logic [31:0] gv = {12'h0, TOUCH_CONTROLLER_GUARD, DAC_GUARD,
        COMPARATOR_GUARD, ADC_GUARD, TIMER_COUNTER_GUARD,
        SERIAL_INTERFACE_GUARD, EVENT_SYSTEM_GUARD, 1'b0};
    wire logic acc = PSEL && PENABLE && PREADY;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);
    sequence wr_at(logic [7:0] a);
        acc && PWRITE && PADDR == a ##2 1'b1;
    endsequence
    chk_ready_next: assert property (PSEL && !PENABLE && CLOCK_EN
        |=> PREADY) else $error("no ready after setup");
    chk_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready held");
    chk_clear_ones: assert property (wr_at(WPC_OFS_WRITE_PROTECT_CLEAR)
        |-> (gv & $past(PWDATA, 2) & WPC_GUARD_MASK) == 0)
        else $error("one did not clear");
    chk_zero_keeps: assert property (wr_at(WPC_OFS_WRITE_PROTECT_CLEAR)
        |-> ((gv ^ $past(gv)) & ~$past(PWDATA, 2)) == 0)
        else $error("zero changed a guard");
    chk_set_ones: assert property (wr_at(WPC_OFS_WRITE_PROTECT_SET)
        |-> (~gv & $past(PWDATA, 2) & WPC_GUARD_MASK) == 0)
        else $error("one did not set");
    chk_read_state: assert property (acc && !PWRITE && PADDR == 8'h00
        |-> PRDATA == (gv | WPC_RESET_VALUE)) else $error("read mismatch");
    chk_bad_addr: assert property (acc && PADDR != 8'h00
        && PADDR != 8'h04 |-> PSLVERR && PRDATA == WPC_UNMAPPED_READ)
        else $error("unmapped not refused");
    chk_only_write: assert property ($changed(gv)
        |-> $past(acc && PWRITE, 2)) else $error("guard moved alone");
endmodule : wpc_top_props
bind wpc_top wpc_top_props u_props (.CLOCK(CLOCK), .RESET_N(RESET_N),
    .CLOCK_EN(CLOCK_EN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .TOUCH_CONTROLLER_GUARD(TOUCH_CONTROLLER_GUARD),
    .DAC_GUARD(DAC_GUARD), .COMPARATOR_GUARD(COMPARATOR_GUARD),
    .ADC_GUARD(ADC_GUARD), .TIMER_COUNTER_GUARD(TIMER_COUNTER_GUARD),
    .SERIAL_INTERFACE_GUARD(SERIAL_INTERFACE_GUARD),
    .EVENT_SYSTEM_GUARD(EVENT_SYSTEM_GUARD));

/* File: verif/tb_wpc_top.sv */
// testbench: apb traffic against the guard register
`timescale 1ns/1ps
module tb_wpc_top;
    import wpc_pkg::*;
    logic CLOCK = 0, RESET_N = 0, CLOCK_EN = 1, PSEL = 0, PENABLE = 0;
    logic PWRITE = 0, PREADY, PSLVERR, er, t19, t18, t17, t16, t1;
    logic [7:0] PADDR = 0, a, tc;
    logic [5:0] sc;
    logic [31:0] PWDATA = 0, PRDATA, rd, m, d;
    int error_cnt = 0, n_tests = 0, seed = 32'h6cc616b7, i;
    wire logic [31:0] gv = {12'h0, t19, t18, t17, t16, tc, sc, t1, 1'b0};
    wpc_top u_wpc_top (.CLOCK(CLOCK), .RESET_N(RESET_N), .CLOCK_EN(CLOCK_EN),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .TOUCH_CONTROLLER_GUARD(t19), .DAC_GUARD(t18),
        .COMPARATOR_GUARD(t17), .ADC_GUARD(t16), .TIMER_COUNTER_GUARD(tc),
        .SERIAL_INTERFACE_GUARD(sc), .EVENT_SYSTEM_GUARD(t1));
    initial forever #12.5 CLOCK = ~CLOCK;
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : check
    // pready is looked at on rising edges only; the request stands
    // until the edge that sees it high, and only the watchdog ends
    // a wait that never gets an answer
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] dt);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= ad;
        PWDATA <= dt;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        do @(posedge CLOCK); while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
    endtask : apb
    function logic [31:0] nxt(logic [7:0] ad, logic [31:0] dt, cur);
        if (ad == WPC_OFS_WRITE_PROTECT_SET) return cur | (dt & 32'h000f_fffe);
        if (ad == 8'h00) return cur & ~(dt & 32'h000f_fffe);
        return cur;
    endfunction : nxt
    task step(input logic [7:0] ad, input logic [31:0] dt);
        apb(1'b1, ad, dt);
        check({31'h0, er}, {31'h0, ad > 8'h04});
        m = nxt(ad, dt, m);
        apb(1'b0, 8'h00, 32'h0);
        check(rd, m | 32'h0080_0000);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        repeat (2) @(posedge CLOCK);
        check(gv, m);
    endtask : step
    task give_verdict;
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict
    initial begin
        m = 32'h0;
        repeat (3) @(posedge CLOCK);
        RESET_N <= 1'b1;
        @(posedge CLOCK);
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h0080_0000);
        step(8'h04, 32'hffff_ffff);
        step(8'h00, 32'h0);
        for (i = 0; i < 32; i++) begin
            step(8'h00, 32'h1 << i);
            step(8'h04, 32'h1 << i);
        end
        step(8'h40, 32'hffff_ffff);
        for (i = 0; i < 40; i++) begin
            d = $random(seed);
            a = (d[2:1] == 2'b11) ? 8'h40 : {5'h0, d[0], 2'b00};
            step(a, $random(seed));
        end
        // a setup seen while the enable is low must not be answered
        CLOCK_EN <= 1'b0;
        PSEL <= 1'b1;
        PWRITE <= 1'b1;
        PADDR <= WPC_OFS_WRITE_PROTECT_CLEAR;
        PWDATA <= 32'hffff_ffff;
        repeat (2) @(posedge CLOCK);
        check({31'h0, PREADY}, 32'h0);
        check(gv, m);
        PSEL <= 1'b0;
        CLOCK_EN <= 1'b1;
        // a second reset in mid-run brings back the reset word
        RESET_N <= 1'b0;
        m = 32'h0;
        repeat (3) @(posedge CLOCK);
        RESET_N <= 1'b1;
        @(posedge CLOCK);
        apb(1'b0, WPC_OFS_WRITE_PROTECT_CLEAR, 32'h0);
        check(rd, WPC_RESET_VALUE);
        check(gv, m);
        give_verdict();
    end
    initial begin
        repeat (5000) @(posedge CLOCK);
        error_cnt++;
        give_verdict();
    end
endmodule : tb_wpc_top
